// ### rtctc_defs.svh
// Offsets, field positions, reset values and timing counts of the
// time-of-day counters.
// Assumes the includer uses these as plain macros; no logic lives here.
`ifndef RTCTC_DEFS_SVH
`define RTCTC_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define RTCTC_SEC_OFS 16'hf068
`define RTCTC_MIN_OFS 16'hf069
`define RTCTC_HOUR_OFS 16'hf06a
`define RTCTC_CTL_OFS 16'hf06c

// ************************************************************
// Field positions, masks and reset values
// ************************************************************
`define RTCTC_BUSY_BIT 7
`define RTCTC_RUN_BIT 7
`define RTCTC_MODE24_BIT 6
`define RTCTC_INTSEL_BIT 3
`define RTCTC_CTL_MASK 8'hc8
`define RTCTC_CTL_RST 8'h00
`define RTCTC_SEC_RST 7'h00
`define RTCTC_MIN_RST 7'h00
`define RTCTC_HOUR_RST 6'h00
`define RTCTC_ONES_MAX 4'h9
`define RTCTC_TENS60_MAX 3'h5
`define RTCTC_HOUR24_LAST 6'h23
`define RTCTC_HOUR12_LAST 6'h11

// ************************************************************
// Timing
// ************************************************************
`define RTCTC_CLK_HZ 40000000
`define RTCTC_SEC_MS 1000
`define RTCTC_BUSY_US 62500
`define RTCTC_SEC_CYCLES (`RTCTC_CLK_HZ / 1000 * `RTCTC_SEC_MS)
`define RTCTC_BUSY_CYCLES (`RTCTC_CLK_HZ / 1000000 * `RTCTC_BUSY_US)
`define RTCTC_TICK_W 26
`define RTCTC_BUSY_W 22

`endif

// ### rtctc_pkg.sv
// Types shared by the time-of-day counter files.
// Assumes rtctc_defs.svh carries the numbers.
package rtctc_pkg;

  // Register port request, one cycle per strobe
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rtctc_req_s;

  // Update sequencer
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } rtctc_state_e;

endpackage

// ### rtctc_tick_gen.sv
// One-second enable pulse divided down from the system clock.
// Assumes run comes from logic on the same clock.
`timescale 1ns/1ps
`include "rtctc_defs.svh"

module rtctc_tick_gen #(
  parameter int unsigned DIV = `RTCTC_SEC_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic tick
);

  localparam int unsigned LAST_I = DIV - 1;
  localparam logic [`RTCTC_TICK_W-1:0] LAST = LAST_I[`RTCTC_TICK_W-1:0];

  logic [`RTCTC_TICK_W-1:0] cnt_q;
  logic at_last;

  assign at_last = (cnt_q == LAST);

  // Stopping clears the prescaler so a restart gives a full second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= at_last ? '0 : cnt_q + 1'b1;
      tick <= at_last;
    end
  end

endmodule

// ### rtctc_time_counters.sv
// Seconds, minutes and hours counters in BCD with a busy flag and a
// first control register, reached over a plain register port.
// Assumes the port master keeps one strobe per cycle and that reset,
// clock-source selection and the day-of-week counter live elsewhere.
//
// Behaviour
// - Bit 7 of every counter register reads 1 while an update is being computed and 0 otherwise.
// - The seconds ones digit steps once a second through 0 to 9.
// - Seconds and minutes tens digits count 0 to 5, giving 60 units per wrap.
// - A ones digit wrapping past 9 bumps its tens digit in the same update.
// - The minutes ones digit steps once a minute through 0 to 9.
// - The hours ones digit steps once an hour through 0 to 9.
// - The hours tens digit sits in bits 5 and 4 and runs 0 to 2.
// - The control register holds a bit choosing when periodic events fire.
// - With that bit 0 events fire in the busy period, with 1 right after it.
// - New values land about 62.5 ms after busy rises, on the same edge where busy drops.
// - Minutes advance on the once-a-minute carry out of seconds.
// - Hours advance on the minute carry and wrap after 11 or 23 by mode.
`timescale 1ns/1ps
`include "rtctc_defs.svh"

module rtctc_time_counters #(
  parameter int unsigned SEC_CYCLES = `RTCTC_SEC_CYCLES,
  parameter int unsigned BUSY_CYCLES = `RTCTC_BUSY_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input rtctc_pkg::rtctc_req_s req,
  output logic [7:0] rd_data,
  output logic update_in_progress,
  output logic sec_event,
  output logic min_event,
  output logic hour_event,
  output logic day_event,
  output logic day_carry
);

  // ************************************************************
  // Registers and decode
  // ************************************************************
  localparam logic [`RTCTC_BUSY_W-1:0] BUSY_LOAD =
    BUSY_CYCLES[`RTCTC_BUSY_W-1:0];

  rtctc_pkg::rtctc_state_e state_q;
  logic [6:0] sec_q;
  logic [6:0] min_q;
  logic [5:0] hour_q;
  logic [7:0] ctl_q;
  logic [`RTCTC_BUSY_W-1:0] busy_cnt_q;
  logic tick;
  logic hit_sec, hit_min, hit_hour, hit_ctl;
  logic wr_sec, wr_min, wr_hour, wr_ctl;
  logic busy, start, commit, int_sel, mode24;
  logic [7:0] rd_mux;

  assign hit_sec = (req.addr == `RTCTC_SEC_OFS);
  assign hit_min = (req.addr == `RTCTC_MIN_OFS);
  assign hit_hour = (req.addr == `RTCTC_HOUR_OFS);
  assign hit_ctl = (req.addr == `RTCTC_CTL_OFS);
  assign wr_sec = req.wr && hit_sec;
  assign wr_min = req.wr && hit_min;
  assign wr_hour = req.wr && hit_hour;
  assign wr_ctl = req.wr && hit_ctl;
  assign busy = (state_q == rtctc_pkg::ST_BUSY);
  assign int_sel = ctl_q[`RTCTC_INTSEL_BIT];
  assign mode24 = ctl_q[`RTCTC_MODE24_BIT];
  assign start = tick && !busy;
  assign commit = busy && (busy_cnt_q == 1);

  // ************************************************************
  // Carry chain
  // ************************************************************
  logic sec_ones_wrap, min_ones_wrap, hour_ones_wrap;
  logic sec_wrap, min_wrap, hour_wrap;
  logic [5:0] hour_last;
  logic [6:0] sec_next, min_next;
  logic [5:0] hour_next;

  // Greater-or-equal so a bad written digit still folds back to 0
  assign sec_ones_wrap = (sec_q[3:0] >= `RTCTC_ONES_MAX);
  assign min_ones_wrap = (min_q[3:0] >= `RTCTC_ONES_MAX);
  assign hour_ones_wrap = (hour_q[3:0] >= `RTCTC_ONES_MAX);
  assign sec_wrap = sec_ones_wrap && (sec_q[6:4] >= `RTCTC_TENS60_MAX);
  assign min_wrap = min_ones_wrap && (min_q[6:4] >= `RTCTC_TENS60_MAX);
  assign hour_last = mode24 ? `RTCTC_HOUR24_LAST : `RTCTC_HOUR12_LAST;
  assign hour_wrap = (hour_q >= hour_last);

  // Ones step, tens bump on ones wrap, seconds and minutes clear on 60, hours past hour_last
  assign sec_next = sec_wrap ? 7'h00 :
    sec_ones_wrap ? {sec_q[6:4] + 3'h1, 4'h0} :
    sec_q + 7'h01;
  assign min_next = !sec_wrap ? min_q :
    min_wrap ? 7'h00 :
    min_ones_wrap ? {min_q[6:4] + 3'h1, 4'h0} :
    min_q + 7'h01;
  assign hour_next = !(sec_wrap && min_wrap) ? hour_q :
    hour_wrap ? 6'h00 :
    hour_ones_wrap ? {hour_q[5:4] + 2'h1, 4'h0} :
    hour_q + 6'h01;

  rtctc_tick_gen #(
    .DIV(SEC_CYCLES)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .run(ctl_q[`RTCTC_RUN_BIT]),
    .tick(tick)
  );

  // ************************************************************
  // Update sequencer
  // ************************************************************
  // Busy spans the whole recompute; values move only at its end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= rtctc_pkg::ST_IDLE;
      busy_cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        rtctc_pkg::ST_IDLE:
        begin
          if (start)
          begin
            state_q <= rtctc_pkg::ST_BUSY;
            busy_cnt_q <= BUSY_LOAD;
          end
        end
        rtctc_pkg::ST_BUSY:
        begin
          busy_cnt_q <= busy_cnt_q - 1'b1;
          if (commit)
          begin
            state_q <= rtctc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Counters: a write in the commit cycle wins, so software can set time
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sec_q <= `RTCTC_SEC_RST;
      min_q <= `RTCTC_MIN_RST;
      hour_q <= `RTCTC_HOUR_RST;
      ctl_q <= `RTCTC_CTL_RST;
    end
    else
    begin
      sec_q <= wr_sec ? req.wdata[6:0] : commit ? sec_next : sec_q;
      min_q <= wr_min ? req.wdata[6:0] : commit ? min_next : min_q;
      hour_q <= wr_hour ? req.wdata[5:0] :
        commit ? hour_next : hour_q;
      ctl_q <= wr_ctl ? (req.wdata & `RTCTC_CTL_MASK) : ctl_q;
    end
  end

  // ************************************************************
  // Events and read port
  // ************************************************************
  logic fire;

  assign fire = (start && !int_sel) || (commit && int_sel);

  // Events fire at busy rise or on the first idle cycle after it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sec_event <= 1'b0;
      min_event <= 1'b0;
      hour_event <= 1'b0;
      day_event <= 1'b0;
      day_carry <= 1'b0;
    end
    else
    begin
      sec_event <= fire;
      min_event <= fire && sec_wrap;
      hour_event <= fire && sec_wrap && min_wrap;
      day_event <= fire && sec_wrap && min_wrap && hour_wrap;
      day_carry <= commit && sec_wrap && min_wrap && hour_wrap;
    end
  end

  // Bit 7 of the counter registers is the live busy state, never stored
  assign rd_mux = hit_sec ? {busy, sec_q} :
    hit_min ? {busy, min_q} :
    hit_hour ? {busy, 1'b0, hour_q} :
    hit_ctl ? ctl_q : 8'h00;
  assign update_in_progress = busy;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rd_data <= 8'h00;
    else
      rd_data <= req.rd ? rd_mux : 8'h00;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic [`RTCTC_BUSY_W:0] busy_len_q;
  logic plain;

  // Busy length measured independently of the down counter
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      busy_len_q <= '0;
    else
      busy_len_q <= busy ? busy_len_q + 1'b1 : '0;
  end
  assign plain = commit && !req.wr;

  a_busy_read_bit: assert property (req.rd && (hit_sec || hit_hour)
    |=> rd_data[7] == $past(busy)) else $error("busy bit wrong");
  a_busy_length: assert property ($fell(busy) |->
    $past(busy_len_q) == BUSY_CYCLES[`RTCTC_BUSY_W:0] - 1'b1)
    else $error("busy length wrong");
  a_sec_ones_step: assert property (plain && sec_q[3:0] < 4'h9
    |=> sec_q == $past(sec_q) + 7'h01) else $error("sec step");
  a_sec_wrap_zero: assert property (plain && sec_q == 7'h59
    |=> sec_q == 7'h00 && min_q != $past(min_q))
    else $error("sec wrap");
  a_tens_carry_bump: assert property (plain && sec_q[3:0] == 4'h9 &&
    sec_q[6:4] < 3'h5 |=> sec_q[3:0] == 4'h0 &&
    sec_q[6:4] == $past(sec_q[6:4]) + 3'h1) else $error("carry");
  a_min_hold_still: assert property (!commit && !wr_min
    |=> $stable(min_q)) else $error("min moved");
  a_hour_mode_wrap: assert property (plain && sec_q == 7'h59 &&
    min_q == 7'h59 && hour_q == hour_last |=> hour_q == 6'h00 &&
    day_carry) else $error("hour wrap");
  a_event_rise_time: assert property ($rose(busy)
    |-> sec_event == !$past(int_sel)) else $error("early event");
  a_event_fall_time: assert property ($fell(busy)
    |-> sec_event == $past(int_sel)) else $error("late event");
  a_write_mask_busy: assert property (wr_sec && !busy && !start
    |=> sec_q == $past(req.wdata[6:0]) && !busy)
    else $error("write");
  a_hour_bit6_zero: assert property (req.rd && hit_hour
    |=> rd_data[6] == 1'b0) else $error("hour bit 6");

  c_commit_seen: cover property (commit);
  c_minute_roll: cover property (plain && sec_wrap);
  c_late_event: cover property ($fell(busy) && sec_event);
  c_busy_read: cover property (req.rd && hit_sec && busy);

endmodule

// ### tb_rtc_time_counters.sv
// Self-checking bench for the BCD time-of-day counters.
// Assumes rtctc_pkg is compiled first and the design runs with short counts.
`timescale 1ns/1ps
`include "rtctc_defs.svh"

module tb_rtc_time_counters;
  // ************************************************************
  // Clock, reset and design
  // ************************************************************
  localparam int unsigned SEC_CYC = 40;
  localparam int unsigned BUSY_CYC = 5;
  logic clk;
  logic reset;
  rtctc_pkg::rtctc_req_s req;
  logic [7:0] rd_data;
  logic update_in_progress;
  logic sec_event;
  logic min_event;
  logic hour_event;
  logic day_event;
  logic day_carry;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_upd = 0;
  int busy_len = 0;
  int len_done = 0;
  logic prev_busy = 1'b0;
  logic [4:0] ev_rise;
  logic [4:0] ev_fall;

  rtctc_time_counters #(
    .SEC_CYCLES(SEC_CYC),
    .BUSY_CYCLES(BUSY_CYC)
  ) u_rtctc_time_counters (
    .clk(clk),
    .reset(reset),
    .req(req),
    .rd_data(rd_data),
    .update_in_progress(update_in_progress),
    .sec_event(sec_event),
    .min_event(min_event),
    .hour_event(hour_event),
    .day_event(day_event),
    .day_carry(day_carry)
  );

  // Free-running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Busy length and event pulses at the start and end of each update
  always @(posedge clk)
  begin
    #1;
    if (update_in_progress === 1'b1 && prev_busy !== 1'b1)
    begin
      busy_len = 1;
      ev_rise = {day_carry, day_event, hour_event, min_event, sec_event};
    end
    else if (update_in_progress === 1'b1)
      busy_len++;
    else if (prev_busy === 1'b1)
    begin
      len_done = busy_len;
      ev_fall = {day_carry, day_event, hour_event, min_event, sec_event};
      n_upd++;
    end
    prev_busy = update_in_progress;
  end

  // Cuts a hang short; the whole run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_of_test();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe is taken
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp,
                       input string msg);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rd_data, exp, msg);
  endtask

  // Loads a time, lets one update run, then stops and checks it
  task automatic upd(input logic [7:0] ctl, s, m, h, es, em, eh,
                     input logic [4:0] ev);
    int n;
    int k;
    begin
      wr(`RTCTC_CTL_OFS, 8'h00);
      wr(`RTCTC_SEC_OFS, s);
      wr(`RTCTC_MIN_OFS, m);
      wr(`RTCTC_HOUR_OFS, h);
      n = n_upd;
      wr(`RTCTC_CTL_OFS, ctl);
      k = 0;
      while (update_in_progress !== 1'b1 && k < 200)
      begin
        @(posedge clk);
        #2 k++;
      end
      // A wait that runs out is a failure, never a silent pass
      if (k >= 200)
      begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: update never started", $time);
      end
      rdchk(`RTCTC_SEC_OFS, {1'b1, s[6:0]}, "busy bit");
      k = 0;
      while (n_upd == n && k < 200)
      begin
        @(posedge clk);
        #2 k++;
      end
      if (k >= 200)
      begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: update never ended", $time);
      end
      wr(`RTCTC_CTL_OFS, 8'h00);
      chk(8'(len_done), 8'(BUSY_CYC), "busy length");
      chk({3'h0, ev_rise}, ctl[3] ? 8'h00 : {4'h0, ev[3:0]}, "early ev");
      chk({3'h0, ev_fall}, {3'h0, ev[4], ctl[3] ? ev[3:0] : 4'h0}, "late ev");
      rdchk(`RTCTC_SEC_OFS, es, "seconds");
      rdchk(`RTCTC_MIN_OFS, em, "minutes");
      rdchk(`RTCTC_HOUR_OFS, eh, "hours");
      $display("update test done at %0t", $time);
    end
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial
  begin
    reset = 1'b1;
    req = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rdchk(`RTCTC_SEC_OFS, 8'h00, "sec reset");
    rdchk(`RTCTC_MIN_OFS, 8'h00, "min reset");
    rdchk(`RTCTC_HOUR_OFS, 8'h00, "hour reset");
    rdchk(`RTCTC_CTL_OFS, 8'h00, "ctl reset");
    $display("reset test done");
    wr(`RTCTC_SEC_OFS, 8'ha5);
    rdchk(`RTCTC_SEC_OFS, 8'h25, "sec write");
    wr(`RTCTC_MIN_OFS, 8'hd7);
    rdchk(`RTCTC_MIN_OFS, 8'h57, "min write");
    wr(`RTCTC_HOUR_OFS, 8'hd3);
    rdchk(`RTCTC_HOUR_OFS, 8'h13, "hour write");
    wr(`RTCTC_CTL_OFS, 8'h37);
    rdchk(`RTCTC_CTL_OFS, 8'h00, "ctl write");
    // Run is on only a few cycles here, far short of one tick
    wr(`RTCTC_CTL_OFS, 8'hff);
    rdchk(`RTCTC_CTL_OFS, `RTCTC_CTL_MASK, "ctl bits");
    wr(`RTCTC_CTL_OFS, 8'h00);
    wr(16'hf06b, 8'h55);
    rdchk(16'hf06b, 8'h00, "unmapped");
    rdchk(16'h0000, 8'h00, "unmapped low");
    $display("access test done");
    upd(8'hc8, 8'h59, 8'h59, 8'h23, 8'h00, 8'h00, 8'h00, 5'h1f);
    upd(8'h80, 8'h59, 8'h59, 8'h11, 8'h00, 8'h00, 8'h00, 5'h1f);
    upd(8'hc0, 8'h59, 8'h59, 8'h09, 8'h00, 8'h00, 8'h10, 5'h07);
    upd(8'h88, 8'h59, 8'h09, 8'h22, 8'h00, 8'h10, 8'h22, 5'h03);
    upd(8'h80, 8'h08, 8'h30, 8'h15, 8'h09, 8'h30, 8'h15, 5'h01);
    upd(8'hc8, 8'h49, 8'h00, 8'h00, 8'h50, 8'h00, 8'h00, 5'h01);
    end_of_test();
  end
endmodule
